// ==== rtl/cycle_seq_pkg.sv ====
// Constants, register map and encodings of the camera cycle sequencer.
package cycle_seq_pkg;

  // Clock and microsecond time base.
  localparam int CLK_PERIOD_PS = 4000;
  localparam int US_PS         = 1000000;
  localparam int TICK_CYCLES   = US_PS / CLK_PERIOD_PS;
  localparam int TICK_W        = 9;

  // Register bus geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets.
  localparam logic [7:0] OFS_CONTROL    = 8'h00;
  localparam logic [7:0] OFS_COMMAND    = 8'h04;
  localparam logic [7:0] OFS_SET_SELECT = 8'h08;
  localparam logic [7:0] OFS_TRIG_WIDTH = 8'h0c;
  localparam logic [7:0] OFS_LIGHT_OFS  = 8'h10;
  localparam logic [7:0] OFS_LIGHT_W    = 8'h14;
  localparam logic [7:0] OFS_MIN_SPACE  = 8'h18;
  localparam logic [7:0] OFS_PERMIT_AT  = 8'h1c;
  localparam logic [7:0] OFS_RUN_LEN    = 8'h20;
  localparam logic [7:0] OFS_STATUS     = 8'h24;
  localparam logic [7:0] OFS_LOST_CNT   = 8'h28;
  localparam logic [7:0] OFS_EVENT_SEL  = 8'h2c;

  // Control register fields.
  localparam int CTL_CYC_ORG_LSB = 0;
  localparam int CTL_BEG_ORG_LSB = 2;
  localparam int CTL_END_ORG_LSB = 4;
  localparam int CTL_DEPTH_LSB   = 8;
  localparam int CTL_ROT_LSB     = 12;

  // Command register bits.
  localparam int CMD_KICK_BIT  = 0;
  localparam int CMD_BEGIN_BIT = 1;
  localparam int CMD_END_BIT   = 2;

  // Event select fields.
  localparam int EVS_CYC_LSB = 0;
  localparam int EVS_BEG_LSB = 4;
  localparam int EVS_END_LSB = 8;
  localparam int N_EVENTS    = 8;

  // Status register fields.
  localparam int STS_ACTIVE_BIT = 0;
  localparam int STS_PEND_LSB   = 4;
  localparam int STS_BUSY_BIT   = 8;
  localparam int STS_SET_LSB    = 12;
  localparam int STS_STOP_BIT   = 16;

  // Origin encodings for cycle trigger and run begin.
  localparam logic [1:0] ORG_IMMEDIATE = 2'h0;
  localparam logic [1:0] ORG_COMMAND   = 2'h1;
  localparam logic [1:0] ORG_EVENT     = 2'h2;

  // Run end encodings.
  localparam logic [1:0] END_COMMAND = 2'h0;
  localparam logic [1:0] END_LENGTH  = 2'h1;
  localparam logic [1:0] END_EVENT   = 2'h2;

  // Reset values, set width and set and depth limits.
  localparam logic [23:0] RST_RUN_LEN = 24'h000001;
  localparam logic [3:0]  RST_SET_SEL = 4'h1;
  localparam int          SET_W       = 4;
  localparam int          MAX_SETS    = 16;
  localparam int          MAX_DEPTH   = 7;

endpackage : cycle_seq_pkg

// ==== rtl/camera_light_controller.sv ====
// Camera and light cycle sequencer with its register slave.
`timescale 1ns/1ps

// Summary of operation
// - Each cycle start gives one permit, and one camera and one light pulse when their width is non-zero.
// - Camera pulse width and light pulse width come from the chosen set.
// - Light leading edge follows camera leading edge by signed offset.
// - Negative offset: light rises at start, camera later by its magnitude.
// - Permit event fires at a software supplied time inside the cycle.
// - No new cycle before the previous cycle issued its permit.
// - Cycle starts are spaced at least the programmed minimum period.
// - Sixteen timing sets; a selector picks the set software accesses.
// - Rotation length 2 to 16 steps sets 0 to length minus one cyclically.
// - Cycles start only while the run is active and memory has room.
// - Non-immediate origin needs a fresh trigger or a pending one.
// - Immediate origin self triggers at run start and every minimum period.
// - Command or event origin takes triggers from kick or selected event.
// - Latch depth limit 0 disables latching, 1 to 7 enables; level readable.
// - Rejected triggers count as lost; deferred ones raise pending level.
// - Trigger is executed at once when active and the manager is ready.
// - Trigger is deferred when active, below limit and not ready, else lost.
// - Immediate run begin activates the run with no further action.
// - Command or event run begin waits for begin command or event.
// - Command run end stops at the next cycle boundary.
// - Length run end stops after the captured cycle count or on command.
// - Event run end stops on command or event at the next boundary.
// - Cycle count is captured at run begin; later writes wait a run.
module camera_light_controller
  import cycle_seq_pkg::*;
#(
  parameter int W      = 24,
  parameter int N_SETS = MAX_SETS
) (
  // Clock and reset.
  input  wire logic              CLK,
  input  wire logic              RESET,
  // Register port.
  input  wire logic [ADDR_W-1:0] REG_ADDR,
  input  wire logic [DATA_W-1:0] REG_WDATA,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  output logic      [DATA_W-1:0] REG_RDATA,
  // Event sources and memory state.
  input  wire logic [N_EVENTS-1:0] EVENT_IN,
  input  wire logic              MEM_ROOM,
  // Camera and light outputs.
  output logic                   CAMERA_TRIG,
  output logic                   LIGHT_STROBE,
  output logic                   NEXT_CYCLE_PERMIT,
  output logic                   CYCLE_START,
  output logic                   RUN_ACTIVE
);

  initial begin
    if (W < 8 || W > 31 || N_SETS < 2 || N_SETS > MAX_SETS) begin
      $error("camera_light_controller: unsupported parameter values");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register state.
  logic [1:0]       cyc_org_q, beg_org_q, end_org_q;
  logic [2:0]       depth_q;
  logic [4:0]       rot_len_q;
  logic [SET_W-1:0] sel_q;
  logic [2:0]       ev_cyc_q, ev_beg_q, ev_end_q;
  logic [W-1:0]     min_space_q, permit_at_q, run_len_q;
  logic [W-1:0]     trig_w_mem [N_SETS];
  logic [W-1:0]     light_ofs_mem [N_SETS];
  logic [W-1:0]     light_w_mem [N_SETS];
  logic [15:0]      lost_q;
  logic [DATA_W-1:0] rdata_q;

  // Write decode. Each register answers to exactly one byte offset, so a
  // write to an unmapped offset simply has no effect.

  wire wr_ctl  = REG_WR && REG_ADDR == OFS_CONTROL;
  wire wr_cmd  = REG_WR && REG_ADDR == OFS_COMMAND;
  wire wr_sel  = REG_WR && REG_ADDR == OFS_SET_SELECT;
  wire wr_tw   = REG_WR && REG_ADDR == OFS_TRIG_WIDTH;
  wire wr_lo   = REG_WR && REG_ADDR == OFS_LIGHT_OFS;
  wire wr_lw   = REG_WR && REG_ADDR == OFS_LIGHT_W;
  wire wr_ms   = REG_WR && REG_ADDR == OFS_MIN_SPACE;
  wire wr_pa   = REG_WR && REG_ADDR == OFS_PERMIT_AT;
  wire wr_rl   = REG_WR && REG_ADDR == OFS_RUN_LEN;
  wire wr_evs  = REG_WR && REG_ADDR == OFS_EVENT_SEL;

  // A selector beyond the stored sets must not alias onto a real set, so
  // such writes are dropped and reads fall back to set 0.
  wire sel_ok  = 32'(sel_q) < N_SETS;
  wire [SET_W-1:0] sel_idx = sel_ok ? sel_q : '0;

  // Command pulses act in the cycle of the write.
  wire kick      = wr_cmd && REG_WDATA[CMD_KICK_BIT];
  wire begin_cmd = wr_cmd && REG_WDATA[CMD_BEGIN_BIT];
  wire end_cmd   = wr_cmd && REG_WDATA[CMD_END_BIT];

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      cyc_org_q   <= ORG_IMMEDIATE;
      beg_org_q   <= ORG_IMMEDIATE;
      end_org_q   <= END_COMMAND;
      depth_q     <= 3'h0;
      rot_len_q   <= 5'h00;
      ev_cyc_q    <= 3'h0;
      ev_beg_q    <= 3'h0;
      ev_end_q    <= 3'h0;
      min_space_q <= '0;
      permit_at_q <= '0;
      run_len_q   <= W'(RST_RUN_LEN);
    end else begin
      if (wr_ctl) begin
        cyc_org_q <= REG_WDATA[CTL_CYC_ORG_LSB +: 2];
        beg_org_q <= REG_WDATA[CTL_BEG_ORG_LSB +: 2];
        end_org_q <= REG_WDATA[CTL_END_ORG_LSB +: 2];
        depth_q   <= REG_WDATA[CTL_DEPTH_LSB +: 3];
        rot_len_q <= REG_WDATA[CTL_ROT_LSB +: 5];
      end
      if (wr_evs) begin
        ev_cyc_q <= REG_WDATA[EVS_CYC_LSB +: 3];
        ev_beg_q <= REG_WDATA[EVS_BEG_LSB +: 3];
        ev_end_q <= REG_WDATA[EVS_END_LSB +: 3];
      end
      if (wr_ms) min_space_q <= REG_WDATA[W-1:0];
      if (wr_pa) permit_at_q <= REG_WDATA[W-1:0];
      if (wr_rl) run_len_q <= REG_WDATA[W-1:0];
    end
  end


  // Timing set storage, written through the selector.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      sel_q <= RST_SET_SEL;
      for (int i = 0; i < N_SETS; i++) begin
        trig_w_mem[i]    <= '0;
        light_ofs_mem[i] <= '0;
        light_w_mem[i]   <= '0;
      end
    end else begin
      if (wr_sel) sel_q <= REG_WDATA[SET_W-1:0];
      if (wr_tw && sel_ok) trig_w_mem[sel_idx] <= REG_WDATA[W-1:0];
      if (wr_lo && sel_ok) light_ofs_mem[sel_idx] <= REG_WDATA[W-1:0];
      if (wr_lw && sel_ok) light_w_mem[sel_idx] <= REG_WDATA[W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Microsecond tick. The divider runs free from reset, so the first tick
  // of a cycle may come anywhere within one microsecond of its start.

  logic [TICK_W-1:0] div_q;
  wire tick = div_q == TICK_W'(TICK_CYCLES - 1);

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) div_q <= '0;
    else div_q <= tick ? '0 : div_q + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequence, trigger and cycle managers.
  logic             active_q, stop_req_q, run_q;
  logic [2:0]       pend_q;
  logic [W-1:0]     done_cnt_q, len_cap_q, space_q;
  logic [SET_W-1:0] cur_set_q;


  // Event selection. Each manager picks its own source from the event
  // inputs, so one source may serve several managers at once.
  wire ev_cyc = EVENT_IN[ev_cyc_q];
  wire ev_beg = EVENT_IN[ev_beg_q];
  wire ev_end = EVENT_IN[ev_end_q];


  // Run begin and run end. A stop request is only remembered here; the
  // run itself ends between cycles, so a pulse is never cut short.
  wire go_run = (beg_org_q == ORG_IMMEDIATE) ||
                begin_cmd ||
                (beg_org_q == ORG_EVENT && ev_beg);
  wire stop_hit = end_cmd ||
                  (end_org_q == END_EVENT && ev_end);
  wire len_hit  = end_org_q == END_LENGTH &&
                  done_cnt_q >= len_cap_q;
  wire end_now  = active_q && !run_q && (stop_req_q || len_hit);


  // Trigger sorting. A trigger is served at once when the cycle manager is
  // ready, parked in the latch when the run is active with depth left, and lost
  // otherwise. The immediate origin never produces a sortable trigger.
  wire cyc_imm = cyc_org_q == ORG_IMMEDIATE;
  wire trig_ev = !cyc_imm && (kick ||
                 (cyc_org_q == ORG_EVENT && ev_cyc));
  wire space_ok = space_q >= min_space_q;
  wire ready = active_q && MEM_ROOM && !run_q &&
               space_ok && !end_now;
  wire pend_use = depth_q != 3'h0 && pend_q != 3'h0;
  wire start = ready &&
               (cyc_imm || trig_ev || pend_use);
  wire take_pend = start && !cyc_imm && !trig_ev;
  wire defer = trig_ev && !ready && active_q &&
               pend_q < depth_q;
  wire lost = trig_ev && !ready && !defer;


  // Rotation is off for lengths 0 and 1 and for lengths above the number
  // of stored sets; the software selector then picks the set.
  wire rot_on = rot_len_q >= 5'h02 && 32'(rot_len_q) <= N_SETS;
  wire [SET_W-1:0] use_set = rot_on ? cur_set_q : sel_idx;
  wire [SET_W-1:0] rot_last = SET_W'(rot_len_q - 5'h01);

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      active_q   <= 1'b0;
      stop_req_q <= 1'b0;
      done_cnt_q <= '0;
      len_cap_q  <= '0;
      cur_set_q  <= '0;
    end else if (!active_q) begin
      if (go_run) begin
        active_q   <= 1'b1;
        done_cnt_q <= '0;
        len_cap_q  <= run_len_q;
        cur_set_q  <= '0;
      end
    end else begin
      if (end_now) begin
        active_q   <= 1'b0;
        stop_req_q <= 1'b0;
      end else if (stop_hit) begin
        stop_req_q <= 1'b1;
      end
      if (start) begin
        done_cnt_q <= done_cnt_q + 1'b1;
        if (rot_on) cur_set_q <= cur_set_q == rot_last ? '0 :
                                 cur_set_q + 1'b1;
      end
    end
  end

  // Pending level and lost trigger counter.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      pend_q <= 3'h0;
      lost_q <= 16'h0000;
    end else begin
      if (end_now) pend_q <= 3'h0;
      else if (defer) pend_q <= pend_q + 1'b1;
      else if (take_pend) pend_q <= pend_q - 1'b1;
      if (lost) lost_q <= lost_q + 1'b1;
    end
  end

  // Spacing counter, saturating, cleared by each start. Saturation keeps a
  // long idle gap from wrapping round and blocking the next start.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) space_q <= '1;
    else if (start) space_q <= '0;
    else if (tick && space_q != '1) space_q <= space_q + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle timing machine.
  logic [W:0] t_q, cam_at_q, cam_end_q, lit_at_q, lit_end_q, permit_q;
  logic       permit_done_q;
  logic       cam_q, lit_q, permit_pulse_q, start_q;


  // The offset is signed. A negative offset delays the camera instead of
  // the light, so both leading edges are placed at non-negative times and
  // the light still precedes the camera by the offset's magnitude.
  // One extra bit keeps pulse ends from wrapping for the largest settings.
  wire [W-1:0] ofs   = light_ofs_mem[use_set];
  wire [W:0]   ofs_x = {ofs[W-1], ofs};
  wire [W:0]   neg_x = (~ofs_x) + 1'b1;
  wire         early = ofs[W-1];
  wire [W:0]   cam_at = early ? neg_x : '0;
  wire [W:0]   lit_at = early ? '0 : ofs_x;
  wire [W:0]   cam_end = cam_at + {1'b0, trig_w_mem[use_set]};
  wire [W:0]   lit_end = lit_at + {1'b0, light_w_mem[use_set]};


  // A cycle ends only once the permit has been issued and both pulses are
  // over, so a permit placed early never lets two cycles overlap.
  wire cam_on = run_q && t_q >= cam_at_q && t_q < cam_end_q;
  wire lit_on = run_q && t_q >= lit_at_q && t_q < lit_end_q;
  wire permit_hit = run_q && !permit_done_q && t_q >= permit_q;
  wire permit_seen = permit_done_q || permit_hit;
  wire cycle_end = run_q && permit_seen &&
                   t_q >= cam_end_q && t_q >= lit_end_q;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      run_q         <= 1'b0;
      permit_done_q <= 1'b0;
      t_q           <= '0;
      cam_at_q      <= '0;
      cam_end_q     <= '0;
      lit_at_q      <= '0;
      lit_end_q     <= '0;
      permit_q      <= '0;
    end else if (start) begin
      run_q         <= 1'b1;
      permit_done_q <= 1'b0;
      t_q           <= '0;
      cam_at_q      <= cam_at;
      cam_end_q     <= cam_end;
      lit_at_q      <= lit_at;
      lit_end_q     <= lit_end;
      permit_q      <= {1'b0, permit_at_q};
    end else if (run_q) begin
      if (permit_hit) permit_done_q <= 1'b1;
      if (cycle_end) run_q <= 1'b0;
      else if (tick) t_q <= t_q + 1'b1;
    end
  end


  // Registered outputs. All pins leave from flip-flops so that the camera
  // and the light see clean edges one clock after the internal state.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      cam_q          <= 1'b0;
      lit_q          <= 1'b0;
      permit_pulse_q <= 1'b0;
      start_q        <= 1'b0;
    end else begin
      cam_q          <= cam_on;
      lit_q          <= lit_on;
      permit_pulse_q <= permit_hit;
      start_q        <= start;
    end
  end

  assign CAMERA_TRIG       = cam_q;
  assign LIGHT_STROBE      = lit_q;
  assign NEXT_CYCLE_PERMIT = permit_pulse_q;
  assign CYCLE_START       = start_q;
  assign RUN_ACTIVE        = active_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read path. Reads have no side effects, so software may poll status.

  wire [DATA_W-1:0] rd_ctl = DATA_W'({rot_len_q, 1'b0, depth_q, 2'b00,
                                      end_org_q, beg_org_q, cyc_org_q});
  wire [DATA_W-1:0] rd_evs = DATA_W'({1'b0, ev_end_q, 1'b0, ev_beg_q,
                                      1'b0, ev_cyc_q});
  // Status layout: active at bit 0, pending level at 6:4, cycle busy at 8,
  // rotation set at 15:12 and the stop request at bit 16.
  wire [DATA_W-1:0] rd_sts = DATA_W'({stop_req_q, cur_set_q, 3'h0,
                                      run_q, 1'b0, pend_q, 3'h0,
                                      active_q});
  wire [W-1:0] sel_ofs = light_ofs_mem[sel_idx];
  wire [DATA_W-1:0] rd_ofs = {{(DATA_W-W){sel_ofs[W-1]}}, sel_ofs};

  wire [DATA_W-1:0] rd_mux =
    REG_ADDR == OFS_CONTROL    ? rd_ctl :
    REG_ADDR == OFS_SET_SELECT ? DATA_W'(sel_q) :
    REG_ADDR == OFS_TRIG_WIDTH ? DATA_W'(trig_w_mem[sel_idx]) :
    REG_ADDR == OFS_LIGHT_OFS  ? rd_ofs :
    REG_ADDR == OFS_LIGHT_W    ? DATA_W'(light_w_mem[sel_idx]) :
    REG_ADDR == OFS_MIN_SPACE  ? DATA_W'(min_space_q) :
    REG_ADDR == OFS_PERMIT_AT  ? DATA_W'(permit_at_q) :
    REG_ADDR == OFS_RUN_LEN    ? DATA_W'(run_len_q) :
    REG_ADDR == OFS_STATUS     ? rd_sts :
    REG_ADDR == OFS_LOST_CNT   ? DATA_W'(lost_q) :
    REG_ADDR == OFS_EVENT_SEL  ? rd_evs : '0;


  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) rdata_q <= '0;
    else rdata_q <= REG_RD ? rd_mux : '0;
  end

  assign REG_RDATA = rdata_q;

endmodule // camera_light_controller

// ==== dv/camera_light_assertions.sv ====
// Port-level checks of the camera cycle sequencer.
`timescale 1ns/1ps
module camera_light_assertions
  import cycle_seq_pkg::*;
(
  // Clock and reset.
  input wire logic              CLK,
  input wire logic              RESET,
  // Register read port.
  input wire logic              REG_RD,
  input wire logic [DATA_W-1:0] REG_RDATA,
  // Cycle inputs and outputs.
  input wire logic              MEM_ROOM,
  input wire logic              CAMERA_TRIG,
  input wire logic              LIGHT_STROBE,
  input wire logic              NEXT_CYCLE_PERMIT,
  input wire logic              CYCLE_START,
  input wire logic              RUN_ACTIVE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  logic       permit_q;
  logic [1:0] cam_q;
  logic [1:0] light_q;

  ////////////////////////////////////////////////////////////////////////////
  // Permit seen since the last start, and leading edges counted per cycle.
  // Both start high after reset so the first cycle is judged fairly.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      permit_q <= 1'b1;
      cam_q    <= 2'h1;
      light_q  <= 2'h1;
    end else if (CYCLE_START) begin
      permit_q <= NEXT_CYCLE_PERMIT;
      cam_q    <= {1'b0, $rose(CAMERA_TRIG)};
      light_q  <= {1'b0, $rose(LIGHT_STROBE)};
    end else begin
      permit_q <= permit_q | NEXT_CYCLE_PERMIT;
      cam_q    <= cam_q + 2'($rose(CAMERA_TRIG) && cam_q != 2'h3);
      light_q  <= light_q + 2'($rose(LIGHT_STROBE) && light_q != 2'h3);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_start;
    CYCLE_START;
  endsequence
  sequence s_quiet;
    !CYCLE_START;
  endsequence

  start_single_a: assert property (s_start |=> s_quiet)
    else $error("cycle start longer than one cycle");
  permit_single_a: assert property (NEXT_CYCLE_PERMIT |=> !NEXT_CYCLE_PERMIT)
    else $error("permit longer than one cycle");
  start_when_active_a: assert property (s_start |-> RUN_ACTIVE)
    else $error("cycle start outside an active run");
  start_needs_room_a: assert property (s_start |-> $past(MEM_ROOM))
    else $error("cycle start without memory room");
  permit_before_start_a: assert property (s_start |-> permit_q)
    else $error("cycle start before previous permit");
  camera_once_a: assert property (
    $rose(CAMERA_TRIG) && !CYCLE_START |-> cam_q == 2'h0)
    else $error("second camera pulse in one cycle");
  light_once_a: assert property (
    $rose(LIGHT_STROBE) && !CYCLE_START |-> light_q == 2'h0)
    else $error("second light pulse in one cycle");
  rdata_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == '0)
    else $error("read data outside the read answer cycle");
endmodule // camera_light_assertions

bind camera_light_controller camera_light_assertions i_chk (
  .CLK(CLK), .RESET(RESET), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .MEM_ROOM(MEM_ROOM), .CAMERA_TRIG(CAMERA_TRIG),
  .LIGHT_STROBE(LIGHT_STROBE), .NEXT_CYCLE_PERMIT(NEXT_CYCLE_PERMIT),
  .CYCLE_START(CYCLE_START), .RUN_ACTIVE(RUN_ACTIVE));

// ==== dv/camera_light_partner.sv ====
// Behavioural camera and light source that time the pulses they receive.
`timescale 1ns/1ps
module camera_light_partner (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Pulses from the controller.
  input  wire logic cam,
  input  wire logic light,
  // Measurements in clock cycles.
  output int        cam_cnt,
  output int        cam_w,
  output int        light_w,
  output int        lead,
  output int        gap,
  output logic      cam_done
);
  int   now;
  int   cam_t;
  int   light_t;
  logic cam_q;
  logic light_q;

  // Lead is taken at the camera's trailing edge, so early light counts too.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      now = 0;
      cam_q = 1'b0;
      light_q = 1'b0;
      cam_cnt <= 0;
      cam_done <= 1'b0;
    end else begin
      now = now + 1;
      cam_done <= 1'b0;
      if (cam && !cam_q) begin
        gap <= now - cam_t;
        cam_t = now;
        cam_cnt <= cam_cnt + 1;
      end
      if (!cam && cam_q) begin
        cam_w <= now - cam_t;
        lead <= light_t - cam_t;
        cam_done <= 1'b1;
      end
      if (light && !light_q) begin
        light_t = now;
      end
      if (!light && light_q) begin
        light_w <= now - light_t;
      end
      cam_q = cam;
      light_q = light;
    end
  end
endmodule // camera_light_partner

// ==== dv/camera_light_controller_tb_top.sv ====
// Self-checking testbench of the camera cycle sequencer.
`timescale 1ns/1ps
`define CHK(name, exp, got) \
  begin \
    comparisons++; \
    if ((exp) !== (got)) begin \
      n_mismatch++; \
      $display("ERROR %s expected %0h seen %0h", name, exp, got); \
    end \
  end
module camera_light_controller_tb_top
  import cycle_seq_pkg::*;
;
  logic                CLK;
  logic                RESET;
  logic [ADDR_W-1:0]   REG_ADDR;
  logic [DATA_W-1:0]   REG_WDATA;
  logic                REG_WR;
  logic                REG_RD;
  logic [DATA_W-1:0]   REG_RDATA;
  logic [N_EVENTS-1:0] EVENT_IN;
  logic                MEM_ROOM;
  logic                CAMERA_TRIG;
  logic                LIGHT_STROBE;
  logic                RUN_ACTIVE;
  logic                rd_d;
  logic                cam_done;
  logic [31:0]         exp_rd[$];
  logic [31:0]         exp_msk[$];
  logic [31:0]         rnd[4];
  logic [31:0]         e;
  int                  exp_cam[$];
  int                  offs[3] = '{1, 0, -2};
  int                  cam_cnt, cam_w, light_w, lead, gap, base, ew;
  int                  n_mismatch = 0;
  int                  comparisons = 0;

  camera_light_controller i_dut (.CLK(CLK), .RESET(RESET),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .EVENT_IN(EVENT_IN),
    .MEM_ROOM(MEM_ROOM), .CAMERA_TRIG(CAMERA_TRIG),
    .LIGHT_STROBE(LIGHT_STROBE), .NEXT_CYCLE_PERMIT(), .CYCLE_START(),
    .RUN_ACTIVE(RUN_ACTIVE));
  camera_light_partner i_cam (.clk(CLK), .rst(RESET), .cam(CAMERA_TRIG),
    .light(LIGHT_STROBE), .cam_cnt(cam_cnt), .cam_w(cam_w),
    .light_w(light_w), .lead(lead), .gap(gap), .cam_done(cam_done));

  ////////////////////////////////////////////////////////////////////////////
  // Times are checked to within one microsecond tick.
  function automatic int near(input int us, input int clks);
    return (clks > (us - 1) * TICK_CYCLES && clks < (us + 1) * TICK_CYCLES)
      ? us : clks / TICK_CYCLES;
  endfunction

  task automatic complete_run();
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    REG_ADDR  <= a;
    REG_WDATA <= d;
    REG_WR    <= 1'b1;
    @(posedge CLK);
    REG_WR    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic [31:0] m = '1);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_RD   <= 1'b1;
    exp_rd.push_back(x);
    exp_msk.push_back(m);
    @(posedge CLK);
    REG_RD   <= 1'b0;
  endtask

  task automatic pulse(input logic [7:0] v);
    @(posedge CLK);
    EVENT_IN <= v;
    @(posedge CLK);
    EVENT_IN <= '0;
  endtask

  // Waits for expected pulses to finish and the run to reach a level.
  task automatic settle(input logic run);
    int i;
    for (i = 0; i < 20000; i++) begin
      @(posedge CLK);
      if (exp_cam.size() == 0 && CAMERA_TRIG === 1'b0 && RUN_ACTIVE === run)
        break;
    end
    if (i == 20000) begin
      n_mismatch++;
      complete_run();
    end
    repeat (1500) @(posedge CLK);
    `CHK("run_active", run, RUN_ACTIVE)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end

  always @(posedge CLK) rd_d <= REG_RD;

  always @(negedge CLK) begin
    if (rd_d) begin
      e = exp_msk.pop_front();
      `CHK("reg_read", exp_rd.pop_front() & e, REG_RDATA & e)
    end
  end

  always @(posedge CLK) begin
    if (cam_done) begin
      `CHK("cam_expected", 1'b1, exp_cam.size() > 0)
      ew = exp_cam.pop_front();
      `CHK("cam_width", ew, near(ew, cam_w))
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hc5e7));
    RESET = 1'b1;
    REG_ADDR = '0;
    REG_WDATA = '0;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    EVENT_IN = '0;
    MEM_ROOM = 1'b1;
    repeat (5) @(posedge CLK);
    RESET <= 1'b0;
    rd(OFS_SET_SELECT, 32'h1);
    rd(OFS_RUN_LEN, 32'h1);
    rd(OFS_CONTROL, 32'h0);
    rd(8'h3c, 32'h0);
    `CHK("run_default", 1'b1, RUN_ACTIVE)
    wr(OFS_CONTROL, 32'h1);
    for (int s = 0; s < 4; s++) begin
      rnd[s] = $urandom();
      wr(OFS_SET_SELECT, 32'(s));
      wr(OFS_LIGHT_OFS, rnd[s]);
    end
    for (int s = 0; s < 4; s++) begin
      wr(OFS_SET_SELECT, 32'(s));
      rd(OFS_LIGHT_OFS, {{8{rnd[s][23]}}, rnd[s][23:0]});
    end
    wr(OFS_TRIG_WIDTH, 32'h3);
    wr(OFS_LIGHT_W, 32'h1);
    wr(OFS_PERMIT_AT, 32'h4);
    foreach (offs[k]) begin
      wr(OFS_LIGHT_OFS, 32'(offs[k]));
      exp_cam.push_back(3);
      base = cam_cnt;
      wr(OFS_COMMAND, 32'h1);
      settle(1'b1);
      `CHK("cam_count", base + 1, cam_cnt)
      `CHK("light_lead", offs[k], near(offs[k], lead))
      `CHK("light_width", 1, near(1, light_w))
    end
    wr(OFS_COMMAND, 32'h1);
    wr(OFS_COMMAND, 32'h1);
    exp_cam.push_back(3);
    settle(1'b1);
    rd(OFS_LOST_CNT, 32'h1);
    wr(OFS_CONTROL, 32'h201);
    repeat (3) exp_cam.push_back(3);
    repeat (4) wr(OFS_COMMAND, 32'h1);
    rd(OFS_STATUS, 32'h21, 32'h71);
    settle(1'b1);
    rd(OFS_LOST_CNT, 32'h2);
    base = cam_cnt;
    MEM_ROOM <= 1'b0;
    wr(OFS_COMMAND, 32'h1);
    repeat (1500) @(posedge CLK);
    `CHK("held_no_room", base, cam_cnt)
    rd(OFS_STATUS, 32'h11, 32'h10071);
    exp_cam.push_back(3);
    MEM_ROOM <= 1'b1;
    settle(1'b1);
    wr(OFS_EVENT_SEL, 32'h503);
    wr(OFS_CONTROL, 32'h2);
    pulse(8'h04);
    repeat (1500) @(posedge CLK);
    `CHK("other_event", base + 1, cam_cnt)
    exp_cam.push_back(3);
    pulse(8'h08);
    settle(1'b1);
    wr(OFS_CONTROL, 32'h15);
    settle(1'b0);
    for (int s = 0; s < 3; s++) begin
      wr(OFS_SET_SELECT, 32'(s));
      wr(OFS_TRIG_WIDTH, 32'(s + 1));
      wr(OFS_LIGHT_OFS, 32'h0);
    end
    wr(OFS_MIN_SPACE, 32'h7);
    wr(OFS_PERMIT_AT, 32'h0);
    wr(OFS_RUN_LEN, 32'h3);
    wr(OFS_CONTROL, 32'h3014);
    base = cam_cnt;
    exp_cam = '{1, 2, 3};
    wr(OFS_COMMAND, 32'h2);
    wr(OFS_RUN_LEN, 32'h5);
    settle(1'b0);
    `CHK("run_length", base + 3, cam_cnt)
    `CHK("cycle_gap", 7, near(7, gap))
    wr(OFS_TRIG_WIDTH, 32'h0);
    foreach (offs[k]) begin
      wr(OFS_CONTROL, k == 0 ? 32'h24 : 32'h4);
      wr(OFS_COMMAND, 32'h2);
      settle(1'b1);
      if (k == 0)
        pulse(8'h20);
      else
        wr(OFS_COMMAND, 32'h4);
      settle(1'b0);
    end
    complete_run();
  end
endmodule // camera_light_controller_tb_top
